// ---- src/scsi_pci_pkg.sv ----
// Purpose: Shared types and constants for the dual SCSI host PCI front end
// Assumes: One 10 MHz clock, synchronous active-low reset
// Notes:   Config offsets are dword indices into each function's header
`default_nettype none

package scsi_pci_pkg;

    // ------------------------------------------------------------------
    // Bus command codes
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        CMD_INTA   = 4'h0,
        CMD_SPEC   = 4'h1,
        CMD_IO_RD  = 4'h2,
        CMD_IO_WR  = 4'h3,
        CMD_RSV4   = 4'h4,
        CMD_RSV5   = 4'h5,
        CMD_MEM_RD = 4'h6,
        CMD_MEM_WR = 4'h7,
        CMD_RSV8   = 4'h8,
        CMD_RSV9   = 4'h9,
        CMD_CFG_RD = 4'ha,
        CMD_CFG_WR = 4'hb,
        CMD_MRM    = 4'hc,
        CMD_DAC    = 4'hd,
        CMD_MRL    = 4'he,
        CMD_MWI    = 4'hf
    } pci_cmd_t;

    // Decoded target access kind
    typedef enum logic [2:0] {
        KIND_NONE   = 3'b000,
        KIND_CFG_RD = 3'b001,
        KIND_CFG_WR = 3'b010,
        KIND_IO_RD  = 3'b011,
        KIND_IO_WR  = 3'b100,
        KIND_MEM_RD = 3'b101,
        KIND_MEM_WR = 3'b110,
        KIND_ABORT  = 3'b111
    } tgt_kind_t;

    // ------------------------------------------------------------------
    // Config space layout (dword index) and bit positions
    // ------------------------------------------------------------------
    localparam logic [5:0] CFG_IDX_ID = 6'h00;
    localparam logic [5:0] CFG_IDX_CMD = 6'h01;
    localparam logic [5:0] CFG_IDX_CLS = 6'h03;
    localparam logic [5:0] CFG_IDX_IOBAR = 6'h04;
    localparam logic [5:0] CFG_IDX_MEMLO = 6'h05;
    localparam logic [5:0] CFG_IDX_MEMHI = 6'h06;
    localparam int CMDB_IO_EN = 0;
    localparam int CMDB_MEM_EN = 1;
    localparam int CMDB_MST_EN = 2;
    localparam int CMDB_MWI_EN = 4;
    localparam int CMDB_MRL_SEL = 7;
    localparam int ROM_SEL_BIT = 11;
    localparam logic [15:0] CMD_RESET = 16'h0000;
    localparam logic [7:0] CLS_RESET = 8'h00;
    localparam logic [23:0] IOBAR_RESET = 24'h000000;
    localparam logic [51:0] WIN_RESET = 52'h0;
    localparam logic [7:0] HDR_MULTI = 8'h80;
    localparam logic [3:0] MEMBAR_TYPE64 = 4'h4;
    localparam logic [7:0] IOBAR_FLAG = 8'h01;
    // Arbitrary identity value, not any real maker's code
    localparam logic [31:0] CFG_ID_VALUE = 32'h5a5a_0001;

    // ------------------------------------------------------------------
    // Rates and counts
    // ------------------------------------------------------------------
    localparam logic [7:0] RATE_SE_MBPS = 8'd40;
    localparam logic [7:0] RATE_LVD_MBPS = 8'd160;
    localparam logic [7:0] MASTER_PEAK_MBPS = 8'd133;
    localparam logic [7:0] MAX_BURST_WORDS = 8'd64;

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic valid;
        logic [3:0] cmd;
        logic dac;
        logic idsel;
        logic [63:0] addr;
        logic [3:0] be_n;
        logic par;
        logic [31:0] wdata;
    } tgt_req_t;

    typedef struct packed {
        logic claim;
        tgt_kind_t kind;
        logic func;
        logic perr;
        logic [31:0] rdata;
    } tgt_resp_t;

    typedef struct packed {
        logic valid;
        logic write;
        logic [7:0] len;
        logic [63:0] addr;
    } mst_req_t;

    typedef struct packed {
        logic valid;
        logic [3:0] cmd;
        logic dac;
        logic func;
        logic [7:0] len;
        logic [63:0] addr;
    } mst_cmd_t;

    typedef struct packed {
        logic wide;
        logic drive;
        logic arb;
        logic [3:0] id;
        logic [15:0] data;
    } scsi_tx_t;

    typedef struct packed {
        logic [15:0] data;
        logic [1:0] oe;
        logic [1:0] par;
        logic [15:0] rx;
        logic [3:0] win_id;
        logic win_valid;
        logic [7:0] rate;
    } scsi_lane_t;

endpackage

`default_nettype wire

// ---- src/scsi_lane_unit.sv ----
// Purpose: One SCSI channel's bus-side conventions: parity, arbitration, lanes
// Assumes: bus_in is asynchronous; pwr_down is already synchronised
// Notes:   Outputs are registered; upper lane idle in 8-bit mode
`default_nettype none

module scsi_lane_unit
    import scsi_pci_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Channel setup
    input wire logic lvd_mode,
    input wire logic pwr_down,
    // Transmit side and bus pins
    input wire scsi_tx_t tx,
    input wire logic [15:0] bus_in,
    // Lane state
    output scsi_lane_t lane
);

    // ------------------------------------------------------------------
    // Arbitration winner, low byte outranks high byte
    // ------------------------------------------------------------------
    function automatic logic [4:0] win_of(input logic [15:0] b);
        logic [4:0] w;
        w = 5'h00;
        for (int i = 8; i < 16; i++) begin
            if (b[i]) begin
                w = {1'b1, 4'(i)};
            end
        end
        for (int i = 0; i < 8; i++) begin
            if (b[i]) begin
                w = {1'b1, 4'(i)};
            end
        end
        return w;
    endfunction

    logic [15:0] sync1;
    logic [15:0] sync2;
    scsi_lane_t next_lane;
    logic [15:0] drv;

    // Two-flop synchroniser on the bus pins
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            sync1 <= 16'h0000;
            sync2 <= 16'h0000;
        end else begin
            sync1 <= bus_in;
            sync2 <= sync1;
        end
    end

    // Next lane state from transmit request and sampled bus
    always_comb begin
        next_lane = '0;
        drv = tx.arb ? (16'h0001 << tx.id) : tx.data;
        if (!tx.wide) begin
            drv[15:8] = 8'h00;
        end
        next_lane.data = drv;
        next_lane.par[0] = ~^drv[7:0];
        next_lane.par[1] = ~^drv[15:8];
        // Nothing drives while powered down
        next_lane.oe[0] = (tx.drive | tx.arb) & ~pwr_down;
        next_lane.oe[1] = (tx.drive | tx.arb) & ~pwr_down & tx.wide;
        // Inputs read as zero in power-down, so no toggling reaches logic
        next_lane.rx = pwr_down ? 16'h0000 : sync2;
        {next_lane.win_valid, next_lane.win_id} = win_of(next_lane.rx);
        next_lane.rate = lvd_mode ? RATE_LVD_MBPS : RATE_SE_MBPS;
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            lane <= '{par: 2'b11, default: '0}; // Idle lanes still carry odd parity
        end else begin
            lane <= next_lane;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);

    a_odd_lane_parity: assert property (
        ^{lane.data[7:0], lane.par[0]} && ^{lane.data[15:8], lane.par[1]})
        else $error("lane parity not odd");
    a_narrow_upper_idle: assert property (
        !tx.wide |=> !lane.oe[1] && lane.data[15:8] == 8'h00)
        else $error("upper lane active in narrow mode");
    a_powerdown_gate: assert property (
        pwr_down |=> lane.rx == 16'h0000 && lane.oe == 2'b00)
        else $error("input seen while powered down");
    a_low_byte_wins: assert property (
        lane.win_valid && lane.rx[7:0] != 8'h00 |-> lane.win_id[3] == 1'b0)
        else $error("high byte won over low byte");

endmodule

`default_nettype wire

// ---- src/scsi_pci_front.sv ----
// Purpose: PCI target decode, shared bus master and two SCSI channel fronts
// Assumes: PCI phase inputs are on mclk; strap and SCSI pins are asynchronous
// Notes:   Responses and master commands appear one edge after the request
//
// Summary of operation
// - Never claim INTA, special or reserved; check parity
// - Register-space I/O only as single bytes
// - Full-word memory reads only to ROM space
// - Master uses memory commands only for memory
// - Read multiple and read line act as read
// - Write and invalidate acts as write
// - Dual address claimed on window bits 63:12 match
// - Command bit picks read line or multiple
// - Cache line size sizes extended commands
// - Two functions share one master, multi-function header
// - Separate config and I/O registers per function
// - Each channel wide, 40 or 160 MBps
// - Channel A differential, channel B single-ended wide
// - Master bursts clipped to 64 words, one in flight
// - Odd parity per SCSI byte lane
// - Low byte IDs win arbitration over high
// - Narrow mode leaves upper byte undriven
// - Power-down disables all SCSI inputs
// - Firmware disable hides device from configuration
`default_nettype none

module scsi_pci_front
    import scsi_pci_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Straps and power
    input wire logic fw_disable,
    input wire logic pwr_down,
    // Target side
    input wire tgt_req_t tq,
    output tgt_resp_t tr,
    // Master side
    input wire mst_req_t [1:0] mreq,
    input wire logic mst_busy,
    output logic [1:0] mst_grant,
    output mst_cmd_t mcmd,
    // SCSI channels, index 0 is channel A
    input wire scsi_tx_t [1:0] scsi_tx,
    input wire logic [1:0][15:0] scsi_in,
    output scsi_lane_t [1:0] scsi_lane
);

    // ------------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------------
    function automatic logic one_lane(input logic [3:0] be_n);
        return (be_n == 4'he) || (be_n == 4'hd) || (be_n == 4'hb) || (be_n == 4'h7);
    endfunction

    function automatic logic is_ignored(input logic [3:0] c);
        return (c == CMD_INTA) || (c == CMD_SPEC) || (c == CMD_RSV4) ||
               (c == CMD_RSV5) || (c == CMD_RSV8) || (c == CMD_RSV9);
    endfunction

    function automatic logic is_mem_cmd(input logic [3:0] c);
        return (c == CMD_MEM_RD) || (c == CMD_MEM_WR) || (c == CMD_MRM) ||
               (c == CMD_MRL) || (c == CMD_MWI);
    endfunction

    // Master command choice from length, line size and command bits
    function automatic logic [3:0] pick_cmd(input logic wr, input logic [7:0] len,
                                            input logic [7:0] cls, input logic [15:0] cr);
        logic line_ok;
        line_ok = (cls != 8'h00) && (len >= cls);
        if (wr) begin
            return (cr[CMDB_MWI_EN] && line_ok) ? CMD_MWI : CMD_MEM_WR;
        end
        if (len > 8'd1 && line_ok) begin
            return cr[CMDB_MRL_SEL] ? CMD_MRL : CMD_MRM;
        end
        return CMD_MEM_RD;
    endfunction

    // ------------------------------------------------------------------
    // Strap and power-down synchronisers
    // ------------------------------------------------------------------
    logic [1:0] fw_sync;
    logic [1:0] pd_sync;

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            fw_sync <= 2'b00;
            pd_sync <= 2'b00;
        end else begin
            fw_sync <= {fw_sync[0], fw_disable};
            pd_sync <= {pd_sync[0], pwr_down};
        end
    end

    // ------------------------------------------------------------------
    // Per-function config registers
    // ------------------------------------------------------------------
    logic [15:0] cmd_reg [2];
    logic [7:0] cls [2];
    logic [23:0] io_base [2];
    logic [51:0] win [2];
    logic [15:0] next_cmd_reg [2];
    logic [7:0] next_cls [2];
    logic [23:0] next_io_base [2];
    logic [51:0] next_win [2];
    logic [1:0] io_hit;
    logic [1:0] mem_hit;
    tgt_resp_t next_tr;
    logic fsel;
    logic rom;

    // Address match per function; separate windows keep functions apart
    always_comb begin
        for (int f = 0; f < 2; f++) begin
            io_hit[f] = cmd_reg[f][CMDB_IO_EN] && (tq.addr[31:8] == io_base[f]);
            mem_hit[f] = cmd_reg[f][CMDB_MEM_EN] && (tq.addr[63:12] == win[f]);
        end
    end

    // Target decode and config update
    always_comb begin
        next_cmd_reg = cmd_reg;
        next_cls = cls;
        next_io_base = io_base;
        next_win = win;
        next_tr = '0;
        fsel = 1'b0;
        rom = tq.addr[ROM_SEL_BIT];
        if (tq.valid && !fw_sync[1]) begin
            next_tr.perr = (^{tq.addr[31:0], tq.cmd}) != tq.par;
            case (tq.cmd)
                CMD_CFG_RD, CMD_CFG_WR: begin
                    // Only functions 0 and 1 exist; others stay silent
                    if (tq.idsel && tq.addr[10:9] == 2'b00) begin
                        fsel = tq.addr[8];
                        next_tr.claim = 1'b1;
                        next_tr.func = fsel;
                        if (tq.cmd == CMD_CFG_RD) begin
                            next_tr.kind = KIND_CFG_RD;
                            case (tq.addr[7:2])
                                CFG_IDX_ID: next_tr.rdata = CFG_ID_VALUE;
                                CFG_IDX_CMD: next_tr.rdata = {16'h0000, cmd_reg[fsel]};
                                CFG_IDX_CLS: begin
                                    next_tr.rdata = {8'h00, HDR_MULTI, 8'h00, cls[fsel]};
                                end
                                CFG_IDX_IOBAR: next_tr.rdata = {io_base[fsel], IOBAR_FLAG};
                                CFG_IDX_MEMLO: begin
                                    next_tr.rdata = {win[fsel][19:0], 8'h00, MEMBAR_TYPE64};
                                end
                                CFG_IDX_MEMHI: next_tr.rdata = win[fsel][51:20];
                                default: next_tr.rdata = 32'h0000_0000;
                            endcase
                        end else begin
                            next_tr.kind = KIND_CFG_WR;
                            case (tq.addr[7:2])
                                CFG_IDX_CMD: next_cmd_reg[fsel] = tq.wdata[15:0];
                                CFG_IDX_CLS: next_cls[fsel] = tq.wdata[7:0];
                                CFG_IDX_IOBAR: next_io_base[fsel] = tq.wdata[31:8];
                                CFG_IDX_MEMLO: next_win[fsel][19:0] = tq.wdata[31:12];
                                CFG_IDX_MEMHI: next_win[fsel][51:20] = tq.wdata;
                                default: next_tr.kind = KIND_CFG_WR;
                            endcase
                        end
                    end
                end
                CMD_IO_RD, CMD_IO_WR: begin
                    if (io_hit != 2'b00) begin
                        fsel = !io_hit[0];
                        next_tr.claim = 1'b1;
                        next_tr.func = fsel;
                        if (!one_lane(tq.be_n)) begin
                            next_tr.kind = KIND_ABORT;
                        end else begin
                            next_tr.kind = (tq.cmd == CMD_IO_RD) ? KIND_IO_RD : KIND_IO_WR;
                        end
                    end
                end
                CMD_MEM_RD, CMD_MRM, CMD_MRL: begin
                    if (mem_hit != 2'b00) begin
                        fsel = !mem_hit[0];
                        next_tr.claim = 1'b1;
                        next_tr.func = fsel;
                        // ROM takes whole words only, registers single bytes
                        if (rom ? (tq.be_n == 4'h0) : one_lane(tq.be_n)) begin
                            next_tr.kind = KIND_MEM_RD;
                        end else begin
                            next_tr.kind = KIND_ABORT;
                        end
                    end
                end
                CMD_MEM_WR, CMD_MWI: begin
                    if (mem_hit != 2'b00) begin
                        fsel = !mem_hit[0];
                        next_tr.claim = 1'b1;
                        next_tr.func = fsel;
                        if (!rom && one_lane(tq.be_n)) begin
                            next_tr.kind = KIND_MEM_WR;
                        end else begin
                            next_tr.kind = KIND_ABORT;
                        end
                    end
                end
                default: next_tr.claim = 1'b0;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            tr <= '0;
            for (int f = 0; f < 2; f++) begin
                cmd_reg[f] <= CMD_RESET;
                cls[f] <= CLS_RESET;
                io_base[f] <= IOBAR_RESET;
                win[f] <= WIN_RESET;
            end
        end else begin
            tr <= next_tr;
            cmd_reg <= next_cmd_reg;
            cls <= next_cls;
            io_base <= next_io_base;
            win <= next_win;
        end
    end

    // ------------------------------------------------------------------
    // Shared bus master, round robin between the two functions
    // ------------------------------------------------------------------
    logic last_func;
    logic next_last_func;
    logic [1:0] ready;
    logic [1:0] next_grant;
    mst_cmd_t next_mcmd;
    logic gsel;

    always_comb begin
        next_mcmd = '0;
        next_grant = 2'b00;
        next_last_func = last_func;
        gsel = 1'b0;
        for (int f = 0; f < 2; f++) begin
            ready[f] = mreq[f].valid && cmd_reg[f][CMDB_MST_EN];
        end
        // One command in flight; the engine's busy stalls the next
        if (ready != 2'b00 && !mst_busy && !mcmd.valid) begin
            gsel = (ready == 2'b11) ? !last_func : ready[1];
            next_grant[gsel] = 1'b1;
            next_last_func = gsel;
            next_mcmd.valid = 1'b1;
            next_mcmd.func = gsel;
            next_mcmd.addr = mreq[gsel].addr;
            next_mcmd.dac = mreq[gsel].addr[63:32] != 32'h0000_0000;
            // Long bursts are clipped; the requester reissues the rest
            next_mcmd.len = (mreq[gsel].len > MAX_BURST_WORDS) ? MAX_BURST_WORDS
                                                                : mreq[gsel].len;
            next_mcmd.cmd = pick_cmd(mreq[gsel].write, next_mcmd.len, cls[gsel],
                                     cmd_reg[gsel]);
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            mcmd <= '0;
            mst_grant <= 2'b00;
            last_func <= 1'b1;
        end else begin
            mcmd <= next_mcmd;
            mst_grant <= next_grant;
            last_func <= next_last_func;
        end
    end

    // ------------------------------------------------------------------
    // SCSI channels: A differential, B single-ended
    // ------------------------------------------------------------------
    for (genvar ch = 0; ch < 2; ch++) begin : g_ch
        scsi_lane_unit u_lane (
            .mclk(mclk),
            .rst_n(rst_n),
            .lvd_mode(ch == 0),
            .pwr_down(pd_sync[1]),
            .tx(scsi_tx[ch]),
            .bus_in(scsi_in[ch]),
            .lane(scsi_lane[ch])
        );
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);

    a_ignore_special: assert property (
        tq.valid && is_ignored(tq.cmd) |=> !tr.claim)
        else $error("ignored command was claimed");
    a_io_byte_only: assert property (
        tq.valid && (tq.cmd == CMD_IO_RD) && !one_lane(tq.be_n)
        |=> tr.kind != KIND_IO_RD)
        else $error("wide I/O read accepted");
    a_rom_word_read: assert property (
        tq.valid && tq.cmd == CMD_MEM_RD && tq.be_n == 4'h0 && !tq.addr[ROM_SEL_BIT]
        |=> tr.kind != KIND_MEM_RD)
        else $error("word read outside ROM accepted");
    a_master_mem_only: assert property (
        mcmd.valid |-> is_mem_cmd(mcmd.cmd))
        else $error("master issued a non-memory command");
    a_multiple_as_read: assert property (
        tq.valid && !fw_sync[1] && (tq.cmd == CMD_MRM || tq.cmd == CMD_MRL) && mem_hit[0]
        && !tq.addr[ROM_SEL_BIT] && one_lane(tq.be_n) |=> tr.kind == KIND_MEM_RD)
        else $error("read multiple not treated as read");
    a_mwi_as_write: assert property (
        tq.valid && !fw_sync[1] && tq.cmd == CMD_MWI && mem_hit[0]
        && !tq.addr[ROM_SEL_BIT] && one_lane(tq.be_n) |=> tr.kind == KIND_MEM_WR)
        else $error("write and invalidate not treated as write");
    a_dac_window: assert property (
        tq.valid && tq.dac && is_mem_cmd(tq.cmd) && mem_hit == 2'b00 |=> !tr.claim)
        else $error("dual address claimed outside window");
    a_line_select: assert property (
        mcmd.valid && (mcmd.cmd == CMD_MRL || mcmd.cmd == CMD_MRM)
        |-> (mcmd.cmd == CMD_MRL) == cmd_reg[mcmd.func][CMDB_MRL_SEL])
        else $error("read line select bit not honoured");
    a_burst_cap: assert property (
        mcmd.valid |-> mcmd.len <= MAX_BURST_WORDS && $past(mcmd.valid) == 1'b0)
        else $error("master burst over cap or back to back");
    a_hidden_cfg: assert property (
        fw_sync[1] && tq.valid |=> !tr.claim)
        else $error("claimed while firmware disabled");

    c_cfg_read: cover property (tr.claim && tr.kind == KIND_CFG_RD && tr.func);
    c_read_line: cover property (mcmd.valid && mcmd.cmd == CMD_MRL);
    c_mwi: cover property (mcmd.valid && mcmd.cmd == CMD_MWI);
    c_alternate: cover property (mst_grant == 2'b01 ##[1:8] mst_grant == 2'b10);

endmodule

`default_nettype wire

// ---- dv/host_model.sv ----
// Purpose: Bridge and memory stand-in that stalls the master during bursts
// Assumes: mcmd is a one-cycle pulse per burst
// Notes:   Busy one cycle per dword, doubled for a slow memory
`default_nettype none
module host_model
    import scsi_pci_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Burst in, stall out
    input wire mst_cmd_t mcmd,
    input wire logic slow,
    output logic mst_busy
);
    timeunit 1ns;
    timeprecision 1ns;
    int left;
    // Count data phases down; no new burst is taken before this ends
    always @(posedge mclk) begin
        if (!rst_n)
            left <= 0;
        else if (mcmd.valid)
            left <= slow ? 2 * mcmd.len : mcmd.len;
        else if (left > 0)
            left <= left - 1;
    end
    assign mst_busy = (left != 0);
endmodule
`default_nettype wire

// ---- dv/tb_top.sv ----
// Purpose: Self-checking bench for the dual SCSI host PCI front
// Assumes: host_model answers the master side
// Notes:   Inputs change 1 ns after the rising edge
`default_nettype none
module tb_top
    import scsi_pci_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk = 0, rst_n = 0, fw_disable = 0, pwr_down = 0, slow = 0, mst_busy;
    tgt_req_t tq = '0;
    tgt_resp_t tr;
    mst_req_t [1:0] mreq = '0;
    logic [1:0] mst_grant;
    mst_cmd_t mcmd;
    scsi_tx_t [1:0] scsi_tx = '0;
    logic [1:0][15:0] scsi_in = '0;
    scsi_lane_t [1:0] scsi_lane;
    logic [3:0] ign [6] = '{4'h0, 4'h1, 4'h4, 4'h5, 4'h8, 4'h9};
    int num_errors = 0;
    int compares = 0;
    logic [3:0] be_n = 4'h0;
    logic par_flip = 0;
    scsi_pci_front uut (.mclk(mclk), .rst_n(rst_n), .fw_disable(fw_disable),
        .pwr_down(pwr_down), .tq(tq), .tr(tr), .mreq(mreq), .mst_busy(mst_busy),
        .mst_grant(mst_grant), .mcmd(mcmd), .scsi_tx(scsi_tx), .scsi_in(scsi_in),
        .scsi_lane(scsi_lane));
    host_model host (.mclk(mclk), .rst_n(rst_n), .mcmd(mcmd), .slow(slow),
        .mst_busy(mst_busy));
    initial forever #50 mclk = ~mclk;
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // One address phase; the answer stands only in the next cycle
    task automatic tgt(input logic [3:0] cmd, input logic [63:0] addr, input logic [31:0] wd);
        @(posedge mclk);
        #1;
        tq = '{1'b1, cmd, |addr[63:32], 1'b1, addr, be_n, ^{addr[31:0], cmd} ^ par_flip, wd};
        @(posedge mclk);
        #1;
        tq.valid = 0;
    endtask
    // Request held until granted, dropped at once after the grant
    task automatic mst(input logic wr, input logic [7:0] len, input logic [3:0] exp);
        int n;
        n = 0;
        @(posedge mclk);
        #1;
        mreq[0] = '{1'b1, wr, len, 64'h1000};
        while (mcmd.valid !== 1'b1 && n < 300) begin
            @(posedge mclk);
            #1;
            n++;
        end
        mreq[0].valid = 0;
        chk({mcmd.cmd, mcmd.dac, mst_grant, mcmd.len, mcmd.func, mcmd.addr[31:0]},
            {exp, 1'b0, 2'b01, len, 1'b0, 32'h1000});
    endtask
    // Target side of function 0; its memory window still starts at zero
    task automatic target_windows();
        tgt(CMD_CFG_WR, 64'h4, 32'h87);
        tgt(CMD_CFG_WR, 64'h10, 32'h1200);
        be_n = 4'he;
        tgt(CMD_IO_RD, 64'h1234, '0);
        chk({tr.claim, tr.kind}, {1'b1, KIND_IO_RD});
        tgt(CMD_MRM, 64'h10, '0);
        chk({tr.claim, tr.kind}, {1'b1, KIND_MEM_RD});
        tgt(CMD_MWI, 64'h10, '0);
        chk({tr.claim, tr.kind}, {1'b1, KIND_MEM_WR});
        be_n = 4'h0;
        tgt(CMD_IO_WR, 64'h1234, '0);
        chk({tr.claim, tr.kind}, {1'b1, KIND_ABORT});
        tgt(CMD_MEM_RD, 64'h10, '0);
        chk({tr.claim, tr.kind}, {1'b1, KIND_ABORT});
        tgt(CMD_MRL, 64'h810, '0);
        chk({tr.claim, tr.kind}, {1'b1, KIND_MEM_RD});
        tgt(CMD_MEM_RD, 64'h1_0000_0810, '0);
        chk(tr.claim, 1'b0);
        tgt(CMD_CFG_WR, 64'h18, 32'h1);
        tgt(CMD_MEM_RD, 64'h1_0000_0810, '0);
        chk({tr.claim, tr.kind}, {1'b1, KIND_MEM_RD});
        par_flip = 1;
        tgt(CMD_SPEC, 64'h0, '0);
        chk({tr.claim, tr.perr}, 2'b01);
        par_flip = 0;
    endtask
    task automatic end_of_test();
        $display("num_errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge mclk);
        #1 rst_n = 1;
        repeat (3) @(posedge mclk);
        for (int f = 0; f < 2; f++) begin
            tgt(CMD_CFG_RD, 64'(f) << 8, '0);
            chk({tr.claim, tr.func, tr.rdata}, {1'b1, f[0], CFG_ID_VALUE});
            tgt(CMD_CFG_RD, (64'(f) << 8) | 64'hc, '0);
            chk(tr.rdata[23:16], HDR_MULTI);
        end
        foreach (ign[i]) begin
            tgt(ign[i], 64'h0, '0);
            chk({tr.claim, tr.perr}, 2'b00);
        end
        // Memory and master on, read-line select, cache line of four
        tgt(CMD_CFG_WR, 64'h4, 32'h86);
        tgt(CMD_CFG_WR, 64'hc, 32'h4);
        mst(1'b0, 8'd8, 4'he);
        mst(1'b1, 8'd2, 4'h7);
        mst(1'b0, 8'd2, 4'h6);
        slow = 1;
        mst(1'b0, 8'd1, 4'h6);
        target_windows();
        scsi_tx[0] = '{1'b1, 1'b0, 1'b1, 4'h3, 16'h0};
        scsi_tx[1] = '{1'b0, 1'b1, 1'b0, 4'h0, 16'h1ff};
        scsi_in[0] = 16'h8001;
        repeat (4) @(posedge mclk);
        #1;
        chk({scsi_lane[0].data, scsi_lane[0].oe, scsi_lane[0].par}, 20'h0008e);
        chk({scsi_lane[1].data, scsi_lane[1].oe, scsi_lane[1].par[0]}, 19'h007fb);
        chk({scsi_lane[0].win_valid, scsi_lane[0].win_id}, 5'h10);
        chk({scsi_lane[0].rate, scsi_lane[1].rate}, {RATE_LVD_MBPS, RATE_SE_MBPS});
        pwr_down = 1;
        repeat (5) @(posedge mclk);
        #1;
        chk({scsi_lane[0].rx, scsi_lane[0].oe, scsi_lane[1].oe}, 20'h0);
        fw_disable = 1;
        repeat (3) @(posedge mclk);
        tgt(CMD_CFG_RD, 64'h0, '0);
        chk(tr, 38'h0);
        end_of_test();
    end
    // Whole run needs well under a thousand cycles
    initial begin
        repeat (3000) @(posedge mclk);
        num_errors++;
        end_of_test();
    end
endmodule
`default_nettype wire
